// [shared/arc_defines.vh]
/*
 * Constants of the analogue reference conditioning block: parameter
 * addresses, reset values, setting ranges and sample timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH

// ==========================================================
// Parameter addresses
`define ARC_ADDR_READING   16'h0902
`define ARC_ADDR_TAU       16'h0904
`define ARC_ADDR_DEADBAND  16'h0912
`define ARC_ADDR_OFFSET    16'h0916
`define ARC_ADDR_CUR_SCALE 16'h2006
`define ARC_ADDR_SPD_SCALE 16'h2106

// ==========================================================
// Reset values
`define ARC_RST_TAU        16'h0000
`define ARC_RST_DEADBAND   16'h0000
`define ARC_RST_OFFSET     16'h0000
`define ARC_RST_CUR_SCALE  16'h012c
`define ARC_RST_SPD_SCALE  16'h0bb8

// ==========================================================
// Setting ranges (signed values as 16-bit patterns)
`define ARC_MV_MAX         16'h2710
`define ARC_MV_MIN         16'hd8f0
`define ARC_OFS_MAX        16'h1388
`define ARC_OFS_MIN        16'hec78
`define ARC_DB_MAX         16'h03e8
`define ARC_SCALE_MAX      16'h7530
`define ARC_SCALE_MIN      16'h8ad0
`define ARC_TAU_MAX        16'h7fff

// ==========================================================
// Timing: sample period in ns, clock period in ns
`define ARC_TICK_NS        250000
`define ARC_CLK_NS         20
// Sample period in 0.01 ms filter units
`define ARC_TICK_TAU_UNITS 38'h00_0000_0019
// Full-scale input in mV, used as scaling divisor
`define ARC_FULL_SCALE_MV  34'h0_0000_2710
// Fraction bits of the filter state
`define ARC_FRAC_BITS      16

// ==========================================================
// Operating mode codes
`define ARC_MODE_CURRENT   2'h1
`define ARC_MODE_SPEED     2'h2

`endif

// [rtl/arc_top.v]
/*
 * Analogue reference conditioning for one input channel: first-order
 * low-pass, offset trim, zero dead band, readable millivolt value and
 * scaled current / speed references with speed clamp.
 * Assumes the converted sample and the control inputs are produced by
 * logic on ref_clk_i, and that the parameter port is driven by the
 * fieldbus parameter handler on the same clock.
 */
`timescale 1ns/1ps
`include "arc_defines.vh"

module arc_top #(
	parameter TICK_CYCLES = `ARC_TICK_NS / `ARC_CLK_NS
) (
	input  wire        ref_clk_i,
	input  wire        reset_i,
	input  wire [15:0] adc_sample_i,
	input  wire [1:0]  mode_i,
	input  wire [15:0] max_speed_i,
	input  wire [15:0] par_addr_i,
	input  wire        par_wr_i,
	input  wire        par_rd_i,
	input  wire [15:0] par_wdata_i,
	output reg  [15:0] par_rdata_o,
	output reg         par_ack_o,
	output reg         par_err_o,
	output reg  [15:0] current_ref_o,
	output reg  [15:0] speed_ref_o,
	output reg         ref_valid_o
);

	// ==========================================================
	// Helpers

	// Clamp a signed 34-bit value to a signed 16-bit window
	function [15:0] arc_clamp;
		input signed [33:0] v;
		input signed [15:0] lo;
		input signed [15:0] hi;
		begin
			if (v > hi)
				arc_clamp = hi;
			else if (v < lo)
				arc_clamp = lo;
			else
				arc_clamp = v[15:0];
		end
	endfunction

	// Scale a mV value by a setting at full scale
	function signed [33:0] arc_scale;
		input signed [15:0] mv;
		input signed [15:0] scale;
		reg signed [33:0] prod;
		begin
			prod = mv * scale;
			arc_scale = prod / $signed(`ARC_FULL_SCALE_MV);
		end
	endfunction

	// ==========================================================
	// Settings
	reg [15:0] tau_ff;
	reg [15:0] deadband_ff;
	reg [15:0] offset_ff;
	reg [15:0] cur_scale_ff;
	reg [15:0] spd_scale_ff;
	reg [15:0] reading_ff;

	// Range check of an incoming write
	reg        wr_ok;
	reg        addr_hit;
	always @*
	begin
		wr_ok    = 1'b0;
		addr_hit = 1'b1;
		case (par_addr_i)
			`ARC_ADDR_TAU:       wr_ok = (par_wdata_i <= `ARC_TAU_MAX);
			`ARC_ADDR_DEADBAND:  wr_ok = (par_wdata_i <= `ARC_DB_MAX);
			`ARC_ADDR_OFFSET:    wr_ok = ($signed(par_wdata_i) <= $signed(`ARC_OFS_MAX)) &&
				($signed(par_wdata_i) >= $signed(`ARC_OFS_MIN));
			`ARC_ADDR_CUR_SCALE,
			`ARC_ADDR_SPD_SCALE: wr_ok = ($signed(par_wdata_i) <= $signed(`ARC_SCALE_MAX)) &&
				($signed(par_wdata_i) >= $signed(`ARC_SCALE_MIN));
			`ARC_ADDR_READING:   wr_ok = 1'b0;
			default:             addr_hit = 1'b0;
		endcase
	end

	// Parameter writes, refused when out of range or read-only
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			tau_ff       <= `ARC_RST_TAU;
			deadband_ff  <= `ARC_RST_DEADBAND;
			offset_ff    <= `ARC_RST_OFFSET;
			cur_scale_ff <= `ARC_RST_CUR_SCALE;
			spd_scale_ff <= `ARC_RST_SPD_SCALE;
		end
		else if (par_wr_i && wr_ok)
		begin
			case (par_addr_i)
				`ARC_ADDR_TAU:       tau_ff       <= par_wdata_i;
				`ARC_ADDR_DEADBAND:  deadband_ff  <= par_wdata_i;
				`ARC_ADDR_OFFSET:    offset_ff    <= par_wdata_i;
				`ARC_ADDR_CUR_SCALE: cur_scale_ff <= par_wdata_i;
				`ARC_ADDR_SPD_SCALE: spd_scale_ff <= par_wdata_i;
				default:             tau_ff       <= tau_ff;
			endcase
		end
	end

	// Read data and acknowledge, one cycle after the strobe
	reg [15:0] nxt_rdata;
	always @*
	begin
		case (par_addr_i)
			`ARC_ADDR_READING:   nxt_rdata = reading_ff;
			`ARC_ADDR_TAU:       nxt_rdata = tau_ff;
			`ARC_ADDR_DEADBAND:  nxt_rdata = deadband_ff;
			`ARC_ADDR_OFFSET:    nxt_rdata = offset_ff;
			`ARC_ADDR_CUR_SCALE: nxt_rdata = cur_scale_ff;
			`ARC_ADDR_SPD_SCALE: nxt_rdata = spd_scale_ff;
			default:             nxt_rdata = 16'h0000;
		endcase
	end

	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			par_rdata_o <= 16'h0000;
			par_ack_o   <= 1'b0;
			par_err_o   <= 1'b0;
		end
		else
		begin
			par_ack_o   <= par_wr_i | par_rd_i;
			par_err_o   <= (par_wr_i & ~wr_ok) | (par_rd_i & ~addr_hit);
			par_rdata_o <= par_rd_i ? nxt_rdata : 16'h0000;
		end
	end

	// ==========================================================
	// Sample tick divider
	reg [31:0] tick_cnt_ff;
	reg        tick_ff;
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff     <= 1'b0;
		end
		else if (tick_cnt_ff == TICK_CYCLES - 1)
		begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff     <= 1'b1;
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
			tick_ff     <= 1'b0;
		end
	end

	// ==========================================================
	// First-order low-pass, state with fraction bits
	reg  signed [37:0] filt_ff;
	wire signed [15:0] sample_sat = arc_clamp({{18{adc_sample_i[15]}}, adc_sample_i},
		`ARC_MV_MIN, `ARC_MV_MAX);
	wire signed [37:0] target     = {{6{sample_sat[15]}}, sample_sat, 16'h0000};
	wire signed [37:0] diff       = target - filt_ff;
	wire signed [37:0] tau_sum    = $signed({22'h00_0000, tau_ff}) + $signed(`ARC_TICK_TAU_UNITS);
	wire signed [43:0] diff_mul   = diff * $signed(`ARC_TICK_TAU_UNITS);
	wire signed [43:0] step_full  = diff_mul / tau_sum;
	wire signed [15:0] filt_mv    = filt_ff[`ARC_FRAC_BITS + 15:`ARC_FRAC_BITS];
	reg                stage1_ff;

	// Update once per tick; zero time constant passes the sample straight
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			filt_ff   <= 38'h00_0000_0000;
			stage1_ff <= 1'b0;
		end
		else
		begin
			stage1_ff <= tick_ff;
			if (tick_ff)
			begin
				if (tau_ff == 16'h0000)
					filt_ff <= target;
				else
					filt_ff <= filt_ff + step_full[37:0];
			end
		end
	end

	// ==========================================================
	// Offset, saturation and dead band
	wire signed [33:0] ofs_sum   = $signed({{18{filt_mv[15]}}, filt_mv}) +
		$signed({{18{offset_ff[15]}}, offset_ff});
	wire signed [15:0] ofs_sat   = arc_clamp(ofs_sum, `ARC_MV_MIN, `ARC_MV_MAX);
	wire signed [16:0] ofs_abs   = ofs_sat[15] ? -$signed({ofs_sat[15], ofs_sat}) :
		$signed({ofs_sat[15], ofs_sat});
	wire               in_band   = (ofs_abs <= $signed({1'b0, deadband_ff}));
	reg                stage2_ff;

	// Corrected value shared by readback and references
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			reading_ff <= 16'h0000;
			stage2_ff  <= 1'b0;
		end
		else
		begin
			stage2_ff <= stage1_ff;
			if (stage1_ff)
				reading_ff <= in_band ? 16'h0000 : ofs_sat;
		end
	end

	// ==========================================================
	// Reference scaling and speed clamp
	wire signed [33:0] cur_raw  = arc_scale(reading_ff, cur_scale_ff);
	wire signed [33:0] spd_raw  = arc_scale(reading_ff, spd_scale_ff);
	wire signed [33:0] spd_lim  = $signed({18'h0_0000, max_speed_i});
	wire signed [33:0] spd_clip = (spd_raw > spd_lim) ? spd_lim :
		(spd_raw < -spd_lim) ? -spd_lim : spd_raw;

	// References drive only in their own operating mode
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			current_ref_o <= 16'h0000;
			speed_ref_o   <= 16'h0000;
			ref_valid_o   <= 1'b0;
		end
		else
		begin
			ref_valid_o <= stage2_ff;
			if (stage2_ff)
			begin
				current_ref_o <= (mode_i == `ARC_MODE_CURRENT) ? cur_raw[15:0] : 16'h0000;
				speed_ref_o   <= (mode_i == `ARC_MODE_SPEED) ? spd_clip[15:0] : 16'h0000;
			end
		end
	end

endmodule // arc_top

// [dv/arc_adc_model.sv]
/* Sample source standing in for the analogue converter of the input pin.
   Assumes the bench sets the pin level; slow_i adds conversion latency. */
`timescale 1ns/1ps
module arc_adc_model (
	input  wire        ref_clk_i,
	input  wire [15:0] level_i,
	input  wire        slow_i,
	output wire [15:0] sample_o
);
	reg     [15:0] pipe_ff [0:3];
	integer        k;
	// ==========================================
	// Conversion delay line, one or four cycles
	always @(posedge ref_clk_i)
	begin
		pipe_ff[0] <= level_i;
		for (k = 1; k < 4; k = k + 1)
			pipe_ff[k] <= pipe_ff[k-1];
	end
	assign sample_o = slow_i ? pipe_ff[3] : pipe_ff[0];
endmodule // arc_adc_model

// [dv/arc_top_sva.sv]
/* Checker on the arc_top ports: parameter handshake, read-only refusal, update rate,
   current reference gating and speed reference clamp. Assumes binding by name to arc_top. */
`timescale 1ns/1ps
`include "arc_defines.vh"
module arc_top_sva #(
	parameter TICK_CYCLES = 12500
) (
	input wire        ref_clk_i,
	input wire        reset_i,
	input wire [1:0]  mode_i,
	input wire [15:0] max_speed_i,
	input wire [15:0] par_addr_i,
	input wire        par_wr_i,
	input wire        par_rd_i,
	input wire [15:0] par_rdata_o,
	input wire        par_ack_o,
	input wire        par_err_o,
	input wire [15:0] current_ref_o,
	input wire [15:0] speed_ref_o,
	input wire        ref_valid_o
);
	reg [31:0] gap_ff;
	reg        seen_ff;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// ==========================================
	// Cycles since the last reference update
	always @(posedge ref_clk_i)
	begin
		gap_ff  <= (reset_i || ref_valid_o) ? 32'h0000_0000 : gap_ff + 32'h0000_0001;
		seen_ff <= reset_i ? 1'b0 : (seen_ff | ref_valid_o);
	end
	a_ack_follows: assert property ((par_wr_i || par_rd_i) |=> par_ack_o)
		else $error("ack missing after strobe");
	a_ack_idle: assert property (!(par_wr_i || par_rd_i) |=> !par_ack_o)
		else $error("ack without strobe");
	a_err_with_ack: assert property (par_err_o |-> par_ack_o)
		else $error("err without ack");
	a_rdata_idle: assert property (!par_ack_o |-> par_rdata_o == 16'h0000)
		else $error("read data not idle");
	a_ro_refused: assert property (par_wr_i && par_addr_i == `ARC_ADDR_READING |=> par_err_o)
		else $error("read-only write accepted");
	a_update_period: assert property (ref_valid_o && seen_ff |-> gap_ff == TICK_CYCLES - 1)
		else $error("update spacing wrong");
	a_cur_gated: assert property ((mode_i != `ARC_MODE_CURRENT)[*3] ##0 ref_valid_o |-> current_ref_o == 16'h0000)
		else $error("current ref outside its mode");
	a_spd_clamp: assert property ($stable(max_speed_i)[*3] ##0 ref_valid_o |->
		$signed(speed_ref_o) <= $signed({1'b0, max_speed_i}) && $signed(speed_ref_o) >= -$signed({1'b0, max_speed_i}))
		else $error("speed ref beyond limit");
endmodule // arc_top_sva
bind arc_top arc_top_sva #(.TICK_CYCLES(TICK_CYCLES)) arc_top_sva_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.mode_i(mode_i), .max_speed_i(max_speed_i), .par_addr_i(par_addr_i), .par_wr_i(par_wr_i), .par_rd_i(par_rd_i),
	.par_rdata_o(par_rdata_o), .par_ack_o(par_ack_o), .par_err_o(par_err_o), .current_ref_o(current_ref_o),
	.speed_ref_o(speed_ref_o), .ref_valid_o(ref_valid_o));

// [dv/analog_reference_conditioning_test.sv]
/* Self-checking bench for arc_top: parameter access, refusals, conditioning.
   Assumes arc_adc_model as sample source and a short tick of 8 cycles. */
`timescale 1ns/1ps
`include "arc_defines.vh"
module analog_reference_conditioning_test;
	reg         ref_clk_i = 1'b0;
	reg         reset_i = 1'b1;
	reg  [15:0] level = 16'h0000;
	reg         slow = 1'b0;
	reg  [1:0]  mode = 2'h0;
	reg  [15:0] max_spd = 16'h0000;
	reg  [15:0] addr = 16'h0000;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg  [15:0] wdata = 16'h0000;
	wire [15:0] smp, rdata, cur, spd;
	wire        ack, err, vld;
	integer     fail_count = 0;
	integer     samples_checked = 0;
	always #10 ref_clk_i = ~ref_clk_i;
	arc_adc_model arc_adc_model_i (.ref_clk_i(ref_clk_i), .level_i(level), .slow_i(slow), .sample_o(smp));
	arc_top #(.TICK_CYCLES(8)) arc_top_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .adc_sample_i(smp),
		.mode_i(mode), .max_speed_i(max_spd), .par_addr_i(addr), .par_wr_i(wr), .par_rd_i(rd),
		.par_wdata_i(wdata), .par_rdata_o(rdata), .par_ack_o(ack), .par_err_o(err),
		.current_ref_o(cur), .speed_ref_o(spd), .ref_valid_o(vld));
	// ==========================================
	// Verdict, compare and access tasks
	task give_verdict;
	begin
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// Strobe one cycle, answer seen at the following falling edge
	task access(input w, input [15:0] a, input [15:0] d, input [15:0] exp, input e);
	begin
		@(negedge ref_clk_i);
		wr = w;
		rd = ~w;
		addr = a;
		wdata = d;
		@(negedge ref_clk_i);
		wr = 1'b0;
		rd = 1'b0;
		chk({15'h0000, ack}, 16'h0001);
		chk({15'h0000, err}, {15'h0000, e});
		if (!w)
			chk(rdata, exp);
	end
	endtask
	task wait_valid;
		integer n;
	begin
		n = 0;
		@(negedge ref_clk_i);
		while (vld !== 1'b1 && n < 40)
		begin
			@(negedge ref_clk_i);
			n = n + 1;
		end
		if (n >= 40)
		begin
			fail_count = fail_count + 1;
			give_verdict;
		end
	end
	endtask
	// Change the pin level just after an update, then wait one update
	task step(input [15:0] v);
	begin
		wait_valid;
		level = v;
		wait_valid;
	end
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (16) @(negedge ref_clk_i);
		reset_i = 1'b0;
		access(0, `ARC_ADDR_CUR_SCALE, 16'h0000, `ARC_RST_CUR_SCALE, 0);
		access(0, `ARC_ADDR_SPD_SCALE, 16'h0000, `ARC_RST_SPD_SCALE, 0);
		access(0, `ARC_ADDR_TAU, 16'h0000, 16'h0000, 0);
		access(0, `ARC_ADDR_DEADBAND, 16'h0000, 16'h0000, 0);
		access(1, `ARC_ADDR_READING, 16'h0001, 16'h0000, 1);
		access(0, 16'h0000, 16'h0000, 16'h0000, 1);
		access(1, `ARC_ADDR_OFFSET, 16'h1389, 16'h0000, 1);
		access(1, `ARC_ADDR_DEADBAND, 16'h03e9, 16'h0000, 1);
		access(1, `ARC_ADDR_TAU, 16'h8000, 16'h0000, 1);
		access(1, `ARC_ADDR_CUR_SCALE, 16'h8acf, 16'h0000, 1);
		access(1, `ARC_ADDR_SPD_SCALE, 16'h7531, 16'h0000, 1);
		access(0, `ARC_ADDR_OFFSET, 16'h0000, 16'h0000, 0);
		access(1, `ARC_ADDR_OFFSET, 16'h0064, 16'h0000, 0);
		access(1, `ARC_ADDR_DEADBAND, 16'h0032, 16'h0000, 0);
		mode = `ARC_MODE_CURRENT;
		step(16'h1388);
		access(0, `ARC_ADDR_READING, 16'h0000, 16'h13ec, 0);
		chk(cur, 16'h0099);
		chk(spd, 16'h0000);
		step(16'hff88);
		access(0, `ARC_ADDR_READING, 16'h0000, 16'h0000, 0);
		chk(cur, 16'h0000);
		access(1, `ARC_ADDR_OFFSET, 16'h0000, 16'h0000, 0);
		access(1, `ARC_ADDR_SPD_SCALE, 16'hf448, 16'h0000, 0);
		mode = `ARC_MODE_SPEED;
		max_spd = 16'h07d0;
		slow = 1'b1;
		step(16'h2328);
		access(0, `ARC_ADDR_READING, 16'h0000, 16'h2328, 0);
		chk(spd, 16'hf830);
		chk(cur, 16'h0000);
		access(1, `ARC_ADDR_OFFSET, 16'h1388, 16'h0000, 0);
		step(16'h2710);
		access(0, `ARC_ADDR_READING, 16'h0000, 16'h2710, 0);
		access(1, `ARC_ADDR_OFFSET, 16'h0000, 16'h0000, 0);
		step(16'h0000);
		access(1, `ARC_ADDR_TAU, 16'h0019, 16'h0000, 0);
		step(16'h03e8);
		access(0, `ARC_ADDR_READING, 16'h0000, 16'h01f4, 0);
		step(16'h03e8);
		access(0, `ARC_ADDR_READING, 16'h0000, 16'h036b, 0);
		give_verdict;
	end
endmodule // analog_reference_conditioning_test
